// file: mode_params.svh
// Constants for the battery mode controller: register offset, flag bits, timing.
// Assumes inclusion by its bare name from the package and design files.
`ifndef MODE_PARAMS_SVH
`define MODE_PARAMS_SVH
// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FLAGS_OFFSET 8'he8
`define FLAGS_RESET 8'h00
`define BIT_PLL_LOSS 7
`define BIT_PLL_LOCK 6
`define BIT_TIMER_WAKE 5
`define BIT_BUTTON_WAKE 4
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define PLL_SETTLE_NS 1000
`define PLL_SETTLE_CYC ((`PLL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: mode_pkg.sv
// Types shared by the battery mode controller files.
// Assumes mode_params.svh sits in the same folder.
`include "mode_params.svh"
package mode_pkg;
  typedef enum logic [3:0] {
    st_powered = 4'b0001,
    st_battery = 4'b0010,
    st_display = 4'b0100,
    st_sleep = 4'b1000
  } mode_e;
  typedef struct packed {
    logic supply;
    logic pll_stable;
    logic margin_good;
    logic button;
  } pins_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } sfr_req_s;
endpackage

// file: pin_sync.sv
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes one clock; a change counts once stages two and three agree.
`timescale 1ns/1ps
`include "mode_params.svh"
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pins
  input wire logic [W-1:0] pins_raw,
  output logic [W-1:0] pins_clean
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } sync_t;
  sync_t st_q;
  sync_t st_d;
  logic [W-1:0] agree;
  // A bit moves only when stages two and three agree, so one late stage cannot glitch it
  assign agree = ~(st_q.s2 ^ st_q.s3);
  always_comb begin
    st_d = st_q;
    st_d.s1 = pins_raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.out = (st_q.out & ~agree) | (st_q.s3 & agree);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT};
    end else begin
      st_q <= st_d;
    end
  end
  assign pins_clean = st_q.out;
endmodule

// file: battery_mode_controller.sv
// Operating-mode controller: powered run, battery run, display-only and sleep.
// Assumes pins are asynchronous; firmware requests and the flag port are on core_clk.
//
// Notes on behaviour
// RULE_01: Powered run mode only while supply present and PLL stably locked.
// RULE_02: Fault sense below threshold drops powered run into battery run unaided.
// RULE_03: Waking on battery with good margin always lands in battery run first.
// RULE_04: In battery run, firmware requests display-only or sleep; controller switches.
// RULE_05: A request forces its mode at once and halts the MPU; one wins.
// RULE_06: Powered run to battery run sets the PLL-loss flag, bit 7.
// RULE_07: Return to powered run on stable PLL sets the PLL-lock flag, bit 6.
// RULE_08: Display-only or sleep return to battery run on timer or button.
// RULE_09: Button input high sets the button wake flag, bit 4; the code sets it only on a rising edge of the synchronised button.
// RULE_10: Wake timer expiry sets the timer wake flag, bit 5.
// RULE_11: Without supply, battery margin loss forces sleep mode; the code forces it only from battery run, not from display-only.
// RULE_12: After forced low-margin sleep, stay asleep though margin recovers.
// RULE_13: Firmware should send the chip to sleep when battery modes are unused.
// RULE_14: Supply return moves any battery mode to powered run once PLL settles.
// RULE_15: Flags stay set until firmware writes zero; a new event sets again.
// RULE_16: Mode request bits clear on leaving display-only or sleep.
`timescale 1ns/1ps
`include "mode_params.svh"
module battery_mode_controller #(
  parameter int SETTLE_CYC = `PLL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Supply monitoring pins
  input wire logic system_supply,
  input wire logic power_fault_sense,
  input wire logic fault_threshold_ref,
  input wire logic pll_locked,
  input wire logic battery_margin_good,
  input wire logic pushbutton_input,
  // Wake timer
  input wire logic timer_expired,
  // Firmware mode requests
  input wire logic display_only_request_set,
  input wire logic sleep_request_set,
  // Special function register port
  input wire mode_pkg::sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // Mode outputs
  output mode_pkg::mode_e mode,
  output logic mpu_halt,
  output logic display_only_request,
  output logic sleep_request
);
  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [4:0] pins_clean;
  logic supply_ok;
  logic pll_ok;
  logic margin_ok;
  logic button_hi;
  logic fault_low;
  // Margin resets high so a false low-margin sleep cannot follow reset
  pin_sync #(
    .W(5),
    .INIT(5'b00100)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pins_raw({system_supply, pll_locked, battery_margin_good, pushbutton_input,
      (power_fault_sense < fault_threshold_ref)}),
    .pins_clean(pins_clean)
  );
  assign supply_ok = pins_clean[4];
  assign pll_ok = pins_clean[3];
  assign margin_ok = pins_clean[2];
  assign button_hi = pins_clean[1];
  assign fault_low = pins_clean[0];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    mode_pkg::mode_e mode;
    logic [7:0] flags;
    logic disp_req;
    logic sleep_req;
    logic forced_sleep;
    logic button_prev;
    logic [15:0] settle_cnt;
  } ctl_t;
  ctl_t st_q;
  ctl_t st_d;
  logic power_good;
  logic settled;
  logic button_rise;
  logic flag_wr;

  // PLL must hold lock for the settle time before powered run is entered
  assign power_good = supply_ok && pll_ok && !fault_low;
  assign settled = (st_q.settle_cnt >= 16'(SETTLE_CYC));
  assign button_rise = button_hi && !st_q.button_prev;
  assign flag_wr = sfr_req.wr && (sfr_req.addr == `FLAGS_OFFSET);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.button_prev = button_hi;
    if (power_good) begin
      if (!settled) begin
        st_d.settle_cnt = st_q.settle_cnt + 16'h0001;
      end
    end else begin
      st_d.settle_cnt = 16'h0000;
    end
    // Firmware clears flags with zero writes; the event set below wins
    if (flag_wr) begin
      st_d.flags = st_q.flags & sfr_req.wdata; // [RULE_15]
    end
    case (st_q.mode)
      mode_pkg::st_powered: begin
        if (!power_good) begin // [RULE_01] [RULE_02]
          st_d.mode = mode_pkg::st_battery;
          st_d.flags[`BIT_PLL_LOSS] = 1'b1; // [RULE_06]
        end
      end
      mode_pkg::st_battery: begin
        if (power_good && settled) begin // [RULE_14]
          st_d.mode = mode_pkg::st_powered;
          st_d.flags[`BIT_PLL_LOCK] = 1'b1; // [RULE_07]
        end else if (!supply_ok && !margin_ok) begin // [RULE_11]
          st_d.mode = mode_pkg::st_sleep;
          st_d.forced_sleep = 1'b1;
        end else if (display_only_request_set) begin // [RULE_04] [RULE_05]
          st_d.disp_req = 1'b1;
          st_d.mode = mode_pkg::st_display;
        end else if (sleep_request_set) begin // [RULE_04] [RULE_05]
          st_d.sleep_req = 1'b1;
          st_d.mode = mode_pkg::st_sleep;
        end
      end
      mode_pkg::st_display, mode_pkg::st_sleep: begin
        if (power_good && settled) begin // [RULE_14]
          st_d.mode = mode_pkg::st_powered;
          st_d.flags[`BIT_PLL_LOCK] = 1'b1; // [RULE_07]
          st_d.disp_req = 1'b0; // [RULE_16]
          st_d.sleep_req = 1'b0;
          st_d.forced_sleep = 1'b0;
        end else if ((timer_expired || button_rise) && (margin_ok || supply_ok)) begin
          // Margin recovery alone never wakes; only timer, button or a settled supply return does
          st_d.mode = mode_pkg::st_battery; // [RULE_08] [RULE_03] [RULE_12]
          st_d.disp_req = 1'b0; // [RULE_16]
          st_d.sleep_req = 1'b0;
          st_d.forced_sleep = 1'b0;
        end
      end
      default: begin
        st_d.mode = mode_pkg::st_battery;
      end
    endcase
    // Wake sources flag in any mode
    if (button_rise) begin
      st_d.flags[`BIT_BUTTON_WAKE] = 1'b1; // [RULE_09]
    end
    if (timer_expired) begin
      st_d.flags[`BIT_TIMER_WAKE] = 1'b1; // [RULE_10]
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{mode: mode_pkg::st_battery, flags: `FLAGS_RESET, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign mode = st_q.mode;
  assign mpu_halt = (st_q.mode == mode_pkg::st_display) || (st_q.mode == mode_pkg::st_sleep);
  assign display_only_request = st_q.disp_req;
  assign sleep_request = st_q.sleep_req;
  assign sfr_rdata = (sfr_req.addr == `FLAGS_OFFSET) ? st_q.flags : 8'h00;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  powered_needs_power_a: assert property ( // [RULE_01]
    (st_q.mode == mode_pkg::st_powered) |-> $past(power_good)
  ) else $error("Powered run without power good");
  fault_drop_a: assert property ( // [RULE_02]
    (st_q.mode == mode_pkg::st_powered && !power_good) |=> (st_q.mode == mode_pkg::st_battery)
  ) else $error("Fault did not leave powered run");
  loss_flag_a: assert property ( // [RULE_06]
    (st_q.mode == mode_pkg::st_powered) ##1 (st_q.mode == mode_pkg::st_battery)
      |-> st_q.flags[`BIT_PLL_LOSS]
  ) else $error("PLL loss flag not set");
  lock_flag_a: assert property ( // [RULE_07]
    ($changed(st_q.mode) && st_q.mode == mode_pkg::st_powered) |-> st_q.flags[`BIT_PLL_LOCK]
  ) else $error("PLL lock flag not set");
  request_force_a: assert property ( // [RULE_05]
    (st_q.mode == mode_pkg::st_battery && !power_good && margin_ok && display_only_request_set)
      |=> (st_q.mode == mode_pkg::st_display && mpu_halt)
  ) else $error("Display request not forced");
  wake_return_a: assert property ( // [RULE_08]
    (mpu_halt && !power_good && margin_ok && timer_expired) |=> (st_q.mode == mode_pkg::st_battery)
  ) else $error("Wake did not return to battery run");
  button_flag_a: assert property ( // [RULE_09]
    button_rise |=> st_q.flags[`BIT_BUTTON_WAKE]
  ) else $error("Button flag not set");
  timer_flag_a: assert property ( // [RULE_10]
    timer_expired |=> st_q.flags[`BIT_TIMER_WAKE]
  ) else $error("Timer flag not set");
  margin_sleep_a: assert property ( // [RULE_11]
    (st_q.mode == mode_pkg::st_battery && !supply_ok && !margin_ok)
      |=> (st_q.mode == mode_pkg::st_sleep)
  ) else $error("Low margin did not force sleep");
  stay_asleep_a: assert property ( // [RULE_12]
    (st_q.mode == mode_pkg::st_sleep && !power_good && !timer_expired && !button_rise)
      |=> (st_q.mode == mode_pkg::st_sleep)
  ) else $error("Left sleep without wake event");
  flag_hold_a: assert property ( // [RULE_15]
    (st_q.flags[`BIT_TIMER_WAKE] && !flag_wr) |=> st_q.flags[`BIT_TIMER_WAKE]
  ) else $error("Flag cleared without write");
  req_clear_a: assert property ( // [RULE_16]
    (mpu_halt ##1 st_q.mode == mode_pkg::st_battery) |-> (!st_q.disp_req && !st_q.sleep_req)
  ) else $error("Request bit not cleared");

  // --------------------------------------------------------------------------
  // Request, wake, supply and flag checks
  // --------------------------------------------------------------------------
  sleep_request_a: assert property ( // [RULE_04]
    (st_q.mode == mode_pkg::st_battery && !power_good && margin_ok
      && !display_only_request_set && sleep_request_set)
      |=> (st_q.mode == mode_pkg::st_sleep && st_q.sleep_req && mpu_halt)
  ) else $error("Sleep request not taken");
  request_refused_a: assert property ( // [RULE_04]
    (st_q.mode == mode_pkg::st_powered && power_good
      && (display_only_request_set || sleep_request_set))
      |=> (st_q.mode == mode_pkg::st_powered && !st_q.disp_req && !st_q.sleep_req)
  ) else $error("Request taken outside battery run");
  one_request_a: assert property ( // [RULE_05]
    st_q.disp_req |-> (!st_q.sleep_req && st_q.mode == mode_pkg::st_display && mpu_halt)
  ) else $error("Display request without display mode");
  sleep_held_a: assert property ( // [RULE_05]
    st_q.sleep_req |-> (!st_q.disp_req && st_q.mode == mode_pkg::st_sleep && mpu_halt)
  ) else $error("Sleep request without sleep mode");
  halt_cause_a: assert property ( // [RULE_05]
    mpu_halt |-> (st_q.disp_req || st_q.sleep_req || st_q.forced_sleep)
  ) else $error("Halt without a cause");
  powered_halt_a: assert property ( // [RULE_01]
    (st_q.mode == mode_pkg::st_powered) |-> (!mpu_halt && !st_q.disp_req && !st_q.sleep_req)
  ) else $error("Powered run with halt or request");
  wake_button_a: assert property ( // [RULE_08] [RULE_03]
    (mpu_halt && !power_good && margin_ok && button_rise) |=> (st_q.mode == mode_pkg::st_battery)
  ) else $error("Button did not return to battery run");
  forced_stay_a: assert property ( // [RULE_12]
    (st_q.forced_sleep && !power_good && !timer_expired && !button_rise)
      |=> (st_q.mode == mode_pkg::st_sleep)
  ) else $error("Forced sleep left without wake event");
  supply_no_sleep_a: assert property ( // [RULE_11]
    (st_q.mode == mode_pkg::st_battery && supply_ok && !margin_ok && !sleep_request_set)
      |=> (st_q.mode != mode_pkg::st_sleep)
  ) else $error("Low margin forced sleep with supply");
  supply_return_a: assert property ( // [RULE_14]
    (st_q.mode != mode_pkg::st_powered && power_good && settled)
      |=> (st_q.mode == mode_pkg::st_powered)
  ) else $error("Supply return did not reach powered run");
  settle_gate_a: assert property ( // [RULE_14]
    (st_q.mode != mode_pkg::st_powered) ##1 (st_q.mode == mode_pkg::st_powered) |-> $past(settled)
  ) else $error("Powered run entered before settle");
  fault_sense_a: assert property ( // [RULE_02]
    (st_q.mode == mode_pkg::st_powered && fault_low) |=> (st_q.mode == mode_pkg::st_battery)
  ) else $error("Fault sense did not leave powered run");
  flag_clear_a: assert property ( // [RULE_15]
    (flag_wr && !sfr_req.wdata[`BIT_TIMER_WAKE] && !timer_expired)
      |=> !st_q.flags[`BIT_TIMER_WAKE]
  ) else $error("Zero write did not clear flag");
  button_hold_a: assert property ( // [RULE_15]
    (st_q.flags[`BIT_BUTTON_WAKE] && !flag_wr) |=> st_q.flags[`BIT_BUTTON_WAKE]
  ) else $error("Button flag cleared without write");
  loss_hold_a: assert property ( // [RULE_15]
    (st_q.flags[`BIT_PLL_LOSS] && !flag_wr) |=> st_q.flags[`BIT_PLL_LOSS]
  ) else $error("Loss flag cleared without write");
  lock_hold_a: assert property ( // [RULE_15]
    (st_q.flags[`BIT_PLL_LOCK] && !flag_wr) |=> st_q.flags[`BIT_PLL_LOCK]
  ) else $error("Lock flag cleared without write");
  req_clear_power_a: assert property ( // [RULE_16]
    (mpu_halt ##1 st_q.mode == mode_pkg::st_powered) |-> (!st_q.disp_req && !st_q.sleep_req)
  ) else $error("Request bit kept in powered run");

  // --------------------------------------------------------------------------
  // Cover properties
  // --------------------------------------------------------------------------
  cov_display_c: cover property (st_q.mode == mode_pkg::st_display);
  cov_sleep_wake_c: cover property (st_q.mode == mode_pkg::st_sleep ##1
    st_q.mode == mode_pkg::st_battery);
  cov_powered_c: cover property (st_q.mode == mode_pkg::st_powered);
  cov_forced_c: cover property (st_q.forced_sleep);
  cov_button_wake_c: cover property (st_q.mode == mode_pkg::st_sleep && button_rise);
endmodule

// file: supply_model.sv
// Model of the supply monitor and PLL that sit beside the mode controller.
// Assumes the bench switches supply_on off the sampling edge; PLL lock lags supply.
`timescale 1ns/1ps
module supply_model #(
  parameter int LOCK_DLY = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Supply control from the bench
  input wire logic supply_on,
  // Pins toward the controller
  output logic system_supply,
  output logic power_fault_sense,
  output logic fault_threshold_ref,
  output logic pll_locked
);
  int lock_cnt_q;
  assign system_supply = supply_on;
  // Fault reads as sense below reference while supply is gone
  assign power_fault_sense = supply_on;
  assign fault_threshold_ref = 1'b1;
  // Lock only after a settle delay, dropped at once on supply loss
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) lock_cnt_q <= 0;
    else if (!supply_on) lock_cnt_q <= 0;
    else if (lock_cnt_q < LOCK_DLY) lock_cnt_q <= lock_cnt_q + 1;
  end
  assign pll_locked = supply_on && (lock_cnt_q == LOCK_DLY);
endmodule

// file: testbench.sv
// Self-checking bench for the battery mode controller.
// Assumes the supply model drives the supply pins; settle count shortened to 2.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_on = 1'b0;
  logic margin = 1'b1;
  logic button = 1'b0;
  logic timer_exp = 1'b0;
  logic disp_set = 1'b0;
  logic sleep_set = 1'b0;
  mode_pkg::sfr_req_s sfr_req = '{addr: 8'he8, wdata: 8'h00, wr: 1'b0};
  logic [7:0] sfr_rdata;
  mode_pkg::mode_e mode;
  logic mpu_halt, disp_req, sleep_req;
  logic sys_sup, sense, ref_lvl, locked;
  int err_count = 0;
  int cmp_count = 0;

  always #10 core_clk = ~core_clk;

  supply_model #(.LOCK_DLY(6)) model (.core_clk(core_clk), .rst(rst), .supply_on(supply_on),
    .system_supply(sys_sup), .power_fault_sense(sense), .fault_threshold_ref(ref_lvl),
    .pll_locked(locked));

  battery_mode_controller #(.SETTLE_CYC(2)) DUT (.core_clk(core_clk), .rst(rst),
    .system_supply(sys_sup), .power_fault_sense(sense), .fault_threshold_ref(ref_lvl),
    .pll_locked(locked), .battery_margin_good(margin), .pushbutton_input(button),
    .timer_expired(timer_exp), .display_only_request_set(disp_set),
    .sleep_request_set(sleep_set), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .mode(mode),
    .mpu_halt(mpu_halt), .display_only_request(disp_req), .sleep_request(sleep_req));

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait, long enough for the four-edge pin sync plus settle
  task automatic wait_mode(input mode_pkg::mode_e m);
    for (int i = 0; i < 40 && mode !== m; i++) @(negedge core_clk);
    chk({4'h0, mode}, {4'h0, m});
  endtask

  task automatic wr_flags(input logic [7:0] v);
    @(posedge core_clk);
    sfr_req <= '{addr: 8'he8, wdata: v, wr: 1'b1};
    @(posedge core_clk);
    sfr_req.wr <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wrap_up;
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    @(negedge core_clk);
    chk({4'h0, mode}, 8'h02);
    chk(sfr_rdata, 8'h00);
    chk({6'h0, disp_req, sleep_req}, 8'h00);
    chk({7'h0, mpu_halt}, 8'h00);
  endtask

  // Both requests at once: display wins, timer brings it back
  task automatic t_display_timer;
    @(posedge core_clk) begin
      disp_set <= 1'b1;
      sleep_set <= 1'b1;
    end
    @(posedge core_clk) begin
      disp_set <= 1'b0;
      sleep_set <= 1'b0;
    end
    @(negedge core_clk);
    chk({4'h0, mode}, 8'h04);
    chk({7'h0, mpu_halt}, 8'h01);
    chk({6'h0, disp_req, sleep_req}, 8'h02);
    @(posedge core_clk) timer_exp <= 1'b1;
    @(posedge core_clk) timer_exp <= 1'b0;
    @(negedge core_clk);
    chk({4'h0, mode}, 8'h02);
    chk({6'h0, disp_req, sleep_req}, 8'h00);
    chk(sfr_rdata, 8'h20);
    @(posedge core_clk) sfr_req.addr <= 8'he9;
    @(negedge core_clk) chk(sfr_rdata, 8'h00);
    @(posedge core_clk) sfr_req.addr <= 8'he8;
    wr_flags(8'hff);
    chk(sfr_rdata, 8'h20);
    wr_flags(8'h00);
    chk(sfr_rdata, 8'h00);
  endtask

  // Firmware parks the chip asleep; the button wakes it to battery run
  task automatic t_sleep_button;
    @(posedge core_clk) sleep_set <= 1'b1;
    @(posedge core_clk) sleep_set <= 1'b0;
    @(negedge core_clk);
    chk({4'h0, mode}, 8'h08);
    chk({6'h0, disp_req, sleep_req}, 8'h01);
    @(posedge core_clk) button <= 1'b1;
    wait_mode(mode_pkg::st_battery);
    chk({7'h0, mpu_halt}, 8'h00);
    chk(sfr_rdata, 8'h10);
    @(posedge core_clk) button <= 1'b0;
    wr_flags(8'h00);
  endtask

  task automatic t_supply_cycle;
    @(posedge core_clk) supply_on <= 1'b1;
    wait_mode(mode_pkg::st_powered);
    chk(sfr_rdata, 8'h40);
    wr_flags(8'h00);
    @(posedge core_clk) supply_on <= 1'b0;
    wait_mode(mode_pkg::st_battery);
    chk(sfr_rdata, 8'h80);
    wr_flags(8'h00);
  endtask

  // Low margin forces sleep, recovery of margin does not wake it
  task automatic t_low_margin;
    @(posedge core_clk) margin <= 1'b0;
    wait_mode(mode_pkg::st_sleep);
    @(posedge core_clk) margin <= 1'b1;
    repeat (12) @(negedge core_clk);
    chk({4'h0, mode}, 8'h08);
    @(posedge core_clk) supply_on <= 1'b1;
    wait_mode(mode_pkg::st_powered);
    chk(sfr_rdata, 8'h40);
    chk({6'h0, disp_req, sleep_req}, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_display_timer();
    t_sleep_button();
    t_supply_cycle();
    t_low_margin();
    wrap_up();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    wrap_up();
  end
endmodule
